// ---- src/energy_pulse_output_formatter.sv ----
// Chosen here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
module energy_pulse_output_formatter
    import pulse_fmt_pkg::*;
#(
    parameter logic [19:0] COUNTER_FORMAT_SEL_WIDTH_CYC = 20'(COUNTER_FORMAT_SEL_CYC)
)
(
    input  wire logic        CLOCK_IN,
    input  wire logic        RST_IN,
    input  wire logic [3:0]  AVS_ADDRESS_IN,
    input  wire logic        AVS_READ_IN,
    input  wire logic        AVS_WRITE_IN,
    input  wire logic [31:0] AVS_WRITEDATA_IN,
    output logic      [31:0] AVS_READDATA_OUT,
    output logic             AVS_WAITREQUEST_OUT,
    input  wire logic [23:0] ENERGY_IN,
    output logic             ENERGY_PULSE_OUT,
    output logic             ENERGY_SIGN_OUT
);

    logic               ack_q;
    logic               ack_d;
    logic [31:0]        rdata_q;
    logic [31:0]        rdata_d;
    fmt_s               ctrl_q;
    fmt_s               ctrl_d;
    logic [23:0]        rate_q;
    logic [23:0]        rate_d;
    logic               req;
    logic               wr_go;

    logic [9:0]         samp_q;
    logic [9:0]         samp_d;
    logic               tick;
    fmt_s               fmt_q;
    fmt_s               fmt_d;
    logic               is_counter_format_sel;
    logic               is_step;
    logic [49:0]        acc_q;
    logic [49:0]        acc_d;
    logic signed [48:0] prod;
    logic [49:0]        prod_x;
    logic               start;
    pulse_state_e       st_q;
    pulse_state_e       st_d;
    logic [19:0]        tmr_q;
    logic [19:0]        tmr_d;
    logic               neg_q;
    logic               neg_d;
    logic [1:0]         ph_q;
    logic [1:0]         ph_d;
    logic               e_q;
    logic               e_d;
    logic               s_q;
    logic               s_d;

    // ---------------- register bus ----------------
    assign req   = AVS_READ_IN | AVS_WRITE_IN;
    assign wr_go = AVS_WRITE_IN & ack_q;
    assign AVS_WAITREQUEST_OUT = req & ~ack_q;
    assign AVS_READDATA_OUT    = rdata_q;

    always_comb
    begin
        ack_d   = req & ~ack_q;
        rdata_d = rdata_q;
        ctrl_d  = ctrl_q;
        rate_d  = rate_q;
        if (AVS_READ_IN && !ack_q)
        begin
            case (AVS_ADDRESS_IN)
                CTRL_OFS: rdata_d = {30'h0, ctrl_q};
                RATE_OFS: rdata_d = {8'h00, rate_q};
                STAT_OFS: rdata_d = {26'h0, neg_q, st_q, fmt_q};
                default:  rdata_d = 32'h0000_0000;
            endcase
        end
        if (wr_go && AVS_ADDRESS_IN == CTRL_OFS)
            ctrl_d = fmt_s'(AVS_WRITEDATA_IN[1:0]);
        if (wr_go && AVS_ADDRESS_IN == RATE_OFS)
            rate_d = AVS_WRITEDATA_IN[23:0];
    end

    always_ff @(posedge CLOCK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
            ctrl_q  <= fmt_s'(CTRL_RST);
            rate_q  <= RATE_RST;
        end
        else
        begin
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
            ctrl_q  <= ctrl_d;
            rate_q  <= rate_d;
        end
    end

    // ---------------- sampling and accumulator ----------------
    // all timing counts clocks, so rates follow the clock feeding the block
    assign tick    = samp_q == 10'(SAMPLE_CYC - 1);
    // reserved 11 decodes as neither, so it runs as normal
    assign is_counter_format_sel = fmt_q.counter & ~fmt_q.stepper;
    assign is_step = fmt_q.stepper & ~fmt_q.counter;
    // energy is weighted by the rate so the quantum is a constant
    assign prod    = $signed(ENERGY_IN) * $signed({1'b0, rate_q});
    assign prod_x  = {prod[48], prod};
    assign start   = (st_q == ST_IDLE) && quantum_due(acc_q);

    always_comb
    begin
        samp_d = samp_q + 10'h001;
        fmt_d  = fmt_q;
        acc_d  = acc_q;
        if (tick && st_q == ST_IDLE)
            fmt_d = ctrl_q;
        if (tick)
            acc_d = acc_d + prod_x;
        // the remainder below a quantum is never cleared
        if (start)
            acc_d = acc_q[49] ? acc_d + QUANTUM : acc_d - QUANTUM;
    end

    always_ff @(posedge CLOCK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            samp_q <= 10'h000;
            fmt_q  <= fmt_s'(CTRL_RST);
            acc_q  <= 50'h0;
        end
        else
        begin
            samp_q <= samp_d;
            fmt_q  <= fmt_d;
            acc_q  <= acc_d;
        end
    end

    // ---------------- pulse engine ----------------
    // gap equals the normal width, so the period is at least 16 clocks, or 9 in stepper format
    always_comb
    begin
        st_d  = st_q;
        tmr_d = tmr_q;
        neg_d = neg_q;
        ph_d  = ph_q;
        case (st_q)
            ST_IDLE:
            begin
                if (start)
                begin
                    neg_d = acc_q[49];
                    if (is_step)
                    begin
                        ph_d  = acc_q[49] ? ph_q - 2'h1 : ph_q + 2'h1;
                        st_d  = ST_GAP;
                        tmr_d = norm_width(rate_q);
                    end
                    else
                    begin
                        st_d  = ST_LOW;
                        tmr_d = is_counter_format_sel ? COUNTER_FORMAT_SEL_WIDTH_CYC
                                        : norm_width(rate_q);
                    end
                end
            end
            ST_LOW:
            begin
                tmr_d = tmr_q - 20'h1;
                if (tmr_q == 20'h1)
                begin
                    st_d  = ST_GAP;
                    tmr_d = norm_width(rate_q);
                end
            end
            ST_GAP:
            begin
                tmr_d = tmr_q - 20'h1;
                if (tmr_q == 20'h1)
                    st_d = ST_IDLE;
            end
            default:
            begin
                st_d  = ST_IDLE;
                tmr_d = 20'h0;
            end
        endcase
    end

    // outputs follow the next state so the pins match the state registers
    always_comb
    begin
        e_d = 1'b1;
        s_d = 1'b1;
        if (fmt_d.stepper && !fmt_d.counter)
        begin
            // phase order 11,01,00,10: energy pin moves first going up
            e_d = ~(ph_d == 2'h1 || ph_d == 2'h2);
            s_d = ~(ph_d == 2'h2 || ph_d == 2'h3);
        end
        else if (st_d == ST_LOW && fmt_d.counter && !fmt_d.stepper)
        begin
            e_d = neg_d;
            s_d = ~neg_d;
        end
        else if (st_d == ST_LOW)
        begin
            e_d = 1'b0;
            s_d = ~neg_d;
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            st_q  <= ST_IDLE;
            tmr_q <= 20'h0;
            neg_q <= 1'b0;
            ph_q  <= 2'h0;
            e_q   <= 1'b1;
            s_q   <= 1'b1;
        end
        else
        begin
            st_q  <= st_d;
            tmr_q <= tmr_d;
            neg_q <= neg_d;
            ph_q  <= ph_d;
            e_q   <= e_d;
            s_q   <= s_d;
        end
    end

    assign ENERGY_PULSE_OUT = e_q;
    assign ENERGY_SIGN_OUT  = s_q;

    // ---------------- checks ----------------
    logic [19:0] low_len_q;
    logic [23:0] hrate_q;
    logic [5:0]  since_q;
    logic [20:0] busy_q;

    always_ff @(posedge CLOCK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            low_len_q <= 20'h0;
            hrate_q   <= 24'h0;
            since_q   <= 6'h3F;
            busy_q    <= 21'h0;
        end
        else
        begin
            busy_q    <= (st_q == ST_IDLE) ? 21'h0 : busy_q + 21'h1;
            low_len_q <= (st_q == ST_LOW) ? low_len_q + 20'h1 : 20'h0;
            if (start)
                hrate_q <= rate_q;
            if (!e_d && e_q)
                since_q <= 6'h0;
            else if (since_q != 6'h3F)
                since_q <= since_q + 6'h1;
        end
    end

    property p_norm_width;
        @(posedge CLOCK_IN) disable iff (RST_IN)
        (st_q == ST_LOW && st_d == ST_GAP && !is_counter_format_sel) |->
            (low_len_q + 20'h1 == norm_width(hrate_q));
    endproperty
    a_norm_width: assert property (p_norm_width)
        else $error("normal pulse width wrong");

    property p_counter_format_sel_width;
        @(posedge CLOCK_IN) disable iff (RST_IN)
        (st_q == ST_LOW && st_d == ST_GAP && is_counter_format_sel) |->
            (low_len_q + 20'h1 == COUNTER_FORMAT_SEL_WIDTH_CYC);
    endproperty
    a_counter_format_sel_width: assert property (p_counter_format_sel_width)
        else $error("counter pulse width wrong");

    property p_max_rate;
        @(posedge CLOCK_IN) disable iff (RST_IN)
        ($fell(ENERGY_PULSE_OUT) && !is_step) |-> ($past(since_q) >= 6'd15);
    endproperty
    a_max_rate: assert property (p_max_rate)
        else $error("pulses too close together");

    property p_sign_norm;
        @(posedge CLOCK_IN) disable iff (RST_IN)
        (!is_counter_format_sel && !is_step) |->
            (neg_q ? ENERGY_SIGN_OUT == ENERGY_PULSE_OUT : ENERGY_SIGN_OUT);
    endproperty
    a_sign_norm: assert property (p_sign_norm)
        else $error("sign pin wrong in normal format");

    property p_counter_format_sel_pins;
        @(posedge CLOCK_IN) disable iff (RST_IN)
        is_counter_format_sel |-> (neg_q ? ENERGY_PULSE_OUT : ENERGY_SIGN_OUT);
    endproperty
    a_counter_format_sel_pins: assert property (p_counter_format_sel_pins)
        else $error("counter pulse on wrong pin");

    property p_acc_hold;
        @(posedge CLOCK_IN) disable iff (RST_IN)
        (!tick && !start) |=> $stable(acc_q);
    endproperty
    a_acc_hold: assert property (p_acc_hold)
        else $error("accumulator moved off boundary");

    property p_residue;
        @(posedge CLOCK_IN) disable iff (RST_IN)
        (tick && !start) |=> (acc_q == $past(acc_q) + $past(prod_x));
    endproperty
    a_residue: assert property (p_residue)
        else $error("residual energy lost");

    property p_burst;
        @(posedge CLOCK_IN) disable iff (RST_IN)
        (st_q != ST_IDLE) |->
            (busy_q <= 21'(COUNTER_FORMAT_SEL_WIDTH_CYC) + 21'(2 * NORM_MAX_W));
    endproperty
    a_burst: assert property (p_burst)
        else $error("pulse engine stuck busy");

    property p_step_one;
        @(posedge CLOCK_IN) disable iff (RST_IN)
        (start && is_step && fmt_d == fmt_q) |=>
            ($changed(ENERGY_PULSE_OUT) != $changed(ENERGY_SIGN_OUT));
    endproperty
    a_step_one: assert property (p_step_one)
        else $error("stepper must toggle exactly one pin");

    property p_fmt_hold;
        @(posedge CLOCK_IN) disable iff (RST_IN)
        !(tick && st_q == ST_IDLE) |=> $stable(fmt_q);
    endproperty
    a_fmt_hold: assert property (p_fmt_hold)
        else $error("format changed off boundary");

    property p_start_burst;
        @(posedge CLOCK_IN) disable iff (RST_IN)
        start |=> (st_q == ST_LOW || st_q == ST_GAP);
    endproperty
    a_start_burst: assert property (p_start_burst)
        else $error("due quantum did not start a pulse");

endmodule

// ---- src/pulse_fmt_pkg.sv ----
// Summary of operation
// - both format bits zero select normal pulses; normal is the reset format
// - normal pulse lasts whole clocks, about one sixteenth of the rate period
// - rate settings below the sample rate keep the width of setting 1024
// - normal energy pulses never come faster than the clock over 16
// - normal sign pin stays high for positive energy, copies pulses when negative
// - hidden signed accumulator adds energy once every 1024 clocks
// - each period with a full quantum gives a burst until below one quantum
// - energy left under one quantum stays in the accumulator for next period
// - counter format gives low pulses 128 ms wide at the reference clock
// - counter format: positive pulses on energy pin, negative on sign pin
// - counter pulse width scales inversely with the clock, fixed cycle count
// - stepper format toggles the two pins alternately, one per quantum
// - stepper: energy pin leads for positive, sign pin leads for negative
// - pulse rates scale linearly with the clock feeding the block
// - each pulse is a fixed quantum; full scale gives the rate setting
package pulse_fmt_pkg;

    localparam logic [3:0]  CTRL_OFS   = 4'h0;
    localparam logic [3:0]  RATE_OFS   = 4'h4;
    localparam logic [3:0]  STAT_OFS   = 4'h8;
    localparam logic [1:0]  CTRL_RST   = 2'h0;
    localparam logic [23:0] RATE_RST   = 24'h000000;
    localparam int          SAMPLE_CYC = 1024;
    localparam int          KNEE_BIT   = 10;
    localparam int          NORM_MAX_W = 64;
    localparam int          NORM_MIN_W = 8;
    localparam int          COUNTER_FORMAT_SEL_MS    = 128;
    localparam int          REF_HZ     = 4096000;
    localparam int          COUNTER_FORMAT_SEL_CYC   = COUNTER_FORMAT_SEL_MS * (REF_HZ / 1000);
    // one quantum = full-scale sample energy times 1024
    localparam logic [49:0] QUANTUM    = 50'h0_0002_0000_0000;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_LOW  = 3'b010,
        ST_GAP  = 3'b100
    } pulse_state_e;

    typedef struct packed
    {
        logic stepper;
        logic counter;
    } fmt_s;

    function automatic logic [19:0] norm_width(input logic [23:0] rate);
        logic [19:0] w;
        w = 20'(NORM_MAX_W);
        for (int i = KNEE_BIT; i < 24; i++)
            if (rate[i])
                w = 20'(NORM_MAX_W) >> (i - KNEE_BIT);
        if (w < 20'(NORM_MIN_W))
            w = 20'(NORM_MIN_W);
        return w;
    endfunction

    function automatic logic quantum_due(input logic [49:0] a);
        return ($signed(a) >= $signed(QUANTUM)) ||
               ($signed(a) <= -$signed(QUANTUM));
    endfunction

endpackage

// ---- verif/pulse_counter_model.sv ----
`timescale 1ns/1ns
module pulse_counter_model
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        energy_n_in,
    input  wire logic        sign_n_in,
    output logic      [7:0]  falls_e_out,
    output logic      [7:0]  falls_s_out,
    output logic      [15:0] width_e_out,
    output logic      [15:0] width_s_out,
    output logic      [1:0]  first_out,
    output logic      [15:0] min_gap_out
);
    logic [15:0] low_e;
    logic [15:0] low_s;
    logic [15:0] gap;
    logic        prev_e;
    logic        prev_s;
    logic        seen;

    // a counter coil only advances on a low level it can follow, so the
    // spacing of falling edges is kept for the bench to judge
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            {falls_e_out, falls_s_out, width_e_out, width_s_out} <= '0;
            {low_e, low_s, gap, seen} <= '0;
            {prev_e, prev_s, first_out} <= 4'hF;
            min_gap_out <= 16'hFFFF;
        end
        else
        begin
            prev_e <= energy_n_in;
            prev_s <= sign_n_in;
            low_e <= energy_n_in ? 16'h0000 : low_e + 16'h0001;
            low_s <= sign_n_in ? 16'h0000 : low_s + 16'h0001;
            gap <= gap + 16'h0001;
            if (prev_e && !energy_n_in)
            begin
                falls_e_out <= falls_e_out + 8'h01;
                gap <= 16'h0001;
                if (falls_e_out != 8'h00 && gap < min_gap_out)
                    min_gap_out <= gap;
            end
            if (prev_s && !sign_n_in)
                falls_s_out <= falls_s_out + 8'h01;
            if (!prev_e && energy_n_in)
                width_e_out <= low_e;
            if (!prev_s && sign_n_in)
                width_s_out <= low_s;
            if (!seen && {energy_n_in, sign_n_in} != 2'b11)
            begin
                seen <= 1'b1;
                first_out <= {energy_n_in, sign_n_in};
            end
        end
    end
endmodule

// ---- verif/test_energy_pulse_output_formatter.sv ----
`timescale 1ns/1ns
module test_energy_pulse_output_formatter
    import pulse_fmt_pkg::*;
;
    typedef struct packed
    {
        logic [1:0]  ctrl;
        logic [23:0] rate;
        logic [23:0] energy;
        logic [3:0]  periods;
        logic [7:0]  fe;
        logic [7:0]  fs;
        logic [15:0] we;
        logic [15:0] ws;
        logic [1:0]  first;
    } case_s;
    typedef struct packed
    {
        logic        wr;
        logic [3:0]  addr;
        logic [31:0] data;
    } reg_s;
    logic        clock;
    logic        rst;
    logic        rd;
    logic        wr;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        wait_req;
    logic [23:0] energy;
    logic        pin_e;
    logic        pin_s;
    logic [7:0]  falls_e;
    logic [7:0]  falls_s;
    logic [15:0] width_e;
    logic [15:0] width_s;
    logic [1:0]  first;
    logic [15:0] min_gap;
    logic [31:0] got;
    int          failures;
    int          num_checks;
    case_s       cases[7];
    reg_s        regs[11];

    energy_pulse_output_formatter #(.COUNTER_FORMAT_SEL_WIDTH_CYC(20'd20)) i_dut
    (
        .CLOCK_IN            (clock),
        .RST_IN              (rst),
        .AVS_ADDRESS_IN      (addr),
        .AVS_READ_IN         (rd),
        .AVS_WRITE_IN        (wr),
        .AVS_WRITEDATA_IN    (wdata),
        .AVS_READDATA_OUT    (rdata),
        .AVS_WAITREQUEST_OUT (wait_req),
        .ENERGY_IN           (energy),
        .ENERGY_PULSE_OUT    (pin_e),
        .ENERGY_SIGN_OUT     (pin_s)
    );

    pulse_counter_model i_far
    (
        .clk_in      (clock),
        .rst_in      (rst),
        .energy_n_in (pin_e),
        .sign_n_in   (pin_s),
        .falls_e_out (falls_e),
        .falls_s_out (falls_s),
        .width_e_out (width_e),
        .width_s_out (width_s),
        .first_out   (first),
        .min_gap_out (min_gap)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        if (failures == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // waitrequest and read data are taken at the rising edge, before the
    // design's registers update in that time step
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        logic busy;
        int   n;
        busy = 1'b1;
        n = 0;
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        while (busy && n < 100)
        begin
            @(posedge clock);
            n++;
            if (wait_req === 1'b0)
            begin
                busy = 1'b0;
                got = rdata;
            end
        end
        if (busy)
            failures++;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clock);
    endtask

    task automatic do_reset;
        rst <= 1'b1;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wait_low;
        int n;
        n = 0;
        while (pin_e !== 1'b0 && n < 3000)
        begin
            @(posedge clock);
            n++;
        end
    endtask

    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial
    begin
        #(40 * 100000);
        failures++;
        finish_test;
    end

    initial
    begin
        {rst, rd, wr, addr, wdata, energy} = {1'b1, 63'h0};
        failures = 0;
        num_checks = 0;
        cases = '{
            '{0, 24'h800, 24'h7FFFFF, 4, 7, 0, 16'h20, 16'h00, 1},
            '{3, 24'h400, 24'h800001, 4, 3, 3, 16'h40, 16'h40, 0},
            '{1, 24'h800, 24'h7FFFFF, 4, 7, 0, 16'h14, 16'h00, 1},
            '{1, 24'h800, 24'h800001, 4, 0, 7, 16'h00, 16'h14, 2},
            '{0, 24'h100, 24'h7FFFFF, 8, 1, 0, 16'h40, 16'h00, 1},
            '{2, 24'h800, 24'h7FFFFF, 4, 2, 2, 16'hFFFF, 16'hFFFF, 1},
            '{2, 24'h400, 24'h800001, 4, 1, 1, 16'hFFFF, 16'hFFFF, 2}};
        regs = '{'{0, 4'h0, 32'h0}, '{0, 4'h4, 32'h0}, '{0, 4'h8, 32'h4},
            '{1, 4'hC, 32'hFFFFFFFF}, '{0, 4'hC, 32'h0},
            '{1, 4'h0, 32'hFFFFFFFF}, '{0, 4'h0, 32'h3},
            '{1, 4'h4, 32'hFFFFFFFF}, '{0, 4'h4, 32'h00FFFFFF},
            '{1, 4'h8, 32'hFFFFFFFF}, '{0, 4'h8, 32'h4}};
        do_reset;
        check({pin_e, pin_s}, 2'b11);
        foreach (regs[i])
        begin
            bus(regs[i].wr, regs[i].addr, regs[i].data);
            if (!regs[i].wr)
                check(got, regs[i].data);
        end
        foreach (cases[i])
        begin
            energy <= cases[i].energy;
            do_reset;
            bus(1'b1, RATE_OFS, {8'h00, cases[i].rate});
            bus(1'b1, CTRL_OFS, {30'h0, cases[i].ctrl});
            repeat (cases[i].periods * SAMPLE_CYC + 200) @(posedge clock);
            check(falls_e, cases[i].fe);
            check(falls_s, cases[i].fs);
            if (cases[i].we != 16'hFFFF)
            begin
                check(width_e, cases[i].we);
                check(width_s, cases[i].ws);
            end
            check(first, cases[i].first);
            check(min_gap >= 16'h0010, 1'b1);
        end
        // format change while a counter pulse is low must not change its width
        energy <= 24'h7FFFFF;
        do_reset;
        bus(1'b1, RATE_OFS, 32'h800);
        bus(1'b1, CTRL_OFS, 32'h1);
        wait_low;
        bus(1'b1, CTRL_OFS, 32'h0);
        repeat (40) @(posedge clock);
        check(width_e, 16'h0014);
        wait_low;
        rst <= 1'b1;
        @(negedge clock);
        check({pin_e, pin_s}, 2'b11);
        @(posedge clock);
        do_reset;
        finish_test;
    end
endmodule
